// *** rtl/timer_pkg.sv ***
// Shared constants, field positions and types of the capture/PWM timer
package timer_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NCH   = 4;
  localparam int NPAIR = 3;
  localparam int CNT_W = 32;
  localparam int PSC_W = 16;
  localparam int DT_W  = 8;
  localparam int CTL_W = 10;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PRESC  = 8'h04;
  localparam logic [7:0] A_RELOAD = 8'h08;
  localparam logic [7:0] A_COUNT  = 8'h0C;
  localparam logic [7:0] A_CHMODE = 8'h10;
  localparam logic [7:0] A_DEAD   = 8'h14;
  localparam logic [3:0] A_CMP_HI = 4'h2;
  localparam logic [7:0] A_STAT   = 8'h30;
  localparam logic [7:0] A_MASK   = 8'h34;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int C_EN   = 0;
  localparam int C_MD   = 1;
  localparam int C_W16  = 3;
  localparam int C_OPM  = 4;
  localparam int C_FRZ  = 5;
  localparam int C_SLV  = 6;
  localparam int C_ENC  = 7;
  localparam int C_HALL = 8;
  localparam int C_DMA  = 9;
  localparam int CH_FW  = 4;
  localparam int CH_FALL = 2;
  localparam int CH_INV  = 3;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [CTL_W-1:0] CTRL_RST   = 10'h000;
  localparam logic [PSC_W-1:0] PRESC_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] RELOAD_RST = 32'hFFFFFFFF;
  localparam logic [DT_W-1:0]  DEAD_RST   = 8'h00;
  localparam logic [CNT_W-1:0] MASK16     = 32'h0000FFFF;
  localparam logic [CNT_W-1:0] MASK32     = 32'hFFFFFFFF;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {
    CNT_UP     = 2'h0,
    CNT_DOWN   = 2'h1,
    CNT_CENTER = 2'h3
  } cnt_mode_t;

  typedef enum logic [1:0] {
    CH_OFF     = 2'h0,
    CH_CAPTURE = 2'h1,
    CH_TOGGLE  = 2'h3,
    CH_PWM     = 2'h2
  } ch_mode_t;

endpackage : timer_pkg

// *** rtl/sync2_bus.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync2_bus
  import timer_pkg::*;
#(
  parameter int W = NCH
)
(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // First stage feeds only the second
  always_comb
  begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.s2;

endmodule : sync2_bus
`default_nettype wire

// *** rtl/dead_time_pair.sv ***
// Complementary output pair with dead-time insertion
`timescale 1ns/1ns
`default_nettype none
module dead_time_pair
  import timer_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            srst,
  input  wire logic            ref_in,
  input  wire logic [DT_W-1:0] dead,
  output logic                 out_p,
  output logic                 out_n
);

  typedef struct packed {
    logic            ref_d;
    logic [DT_W-1:0] cnt;
    logic            p;
    logic            n;
  } dt_state_t;

  dt_state_t s_r;
  dt_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ref_d = ref_in;
    if (ref_in != s_r.ref_d)
    begin
      s_nxt.cnt = dead;
      s_nxt.p = 1'b0;
      s_nxt.n = 1'b0;
    end
    else if (s_r.cnt != '0)
      s_nxt.cnt = s_r.cnt - 8'h01;
    else
    begin
      s_nxt.p = ref_in;
      s_nxt.n = !ref_in;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign out_p = s_r.p;
  assign out_n = s_r.n;

  AST_DT_EXCL: assert property (@(posedge sys_clk) disable iff (srst)
    !(out_p && out_n)) else $error("Both sides of a pair driven");

  AST_DT_GAP: assert property (@(posedge sys_clk) disable iff (srst)
    (ref_in != s_r.ref_d) |=> (!out_p && !out_n)) else $error("No dead gap after edge");

endmodule : dead_time_pair
`default_nettype wire

// *** rtl/capture_pwm_timer.sv ***
// Prescaled capture/compare/PWM timer with dead time, encoder and hall input
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module capture_pwm_timer
  import timer_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [7:0]       addr,
  input  wire logic [CNT_W-1:0] wdata,
  input  wire logic             wr_stb,
  input  wire logic             rd_stb,
  output logic      [CNT_W-1:0] rdata,
  input  wire logic [NCH-1:0]   ch_in,
  input  wire logic             trig_in,
  input  wire logic             dbg_halt,
  output logic      [NCH-1:0]   ch_out,
  output logic      [NPAIR-1:0] ch_out_n,
  output logic                  trig_out,
  output logic                  dma_req,
  output logic                  irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [CTL_W-1:0]          ctrl;
    logic [PSC_W-1:0]          presc;
    logic [PSC_W-1:0]          psc_cnt;
    logic [CNT_W-1:0]          reload;
    logic [CNT_W-1:0]          cnt;
    logic                      dir_dn;
    logic [NCH*CH_FW-1:0]      chmode;
    logic [DT_W-1:0]           dead;
    logic [NCH-1:0][CNT_W-1:0] cmp;
    logic [NCH:0]              stat;
    logic [NCH:0]              mask;
    logic [NCH-1:0]            tgl;
    logic [NCH-1:0]            oc;
    logic [NCH-1:0]            in_d;
    logic                      hall_d;
    logic [CNT_W-1:0]          rdata;
    logic                      dma;
    logic                      trig_o;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  logic [NCH-1:0]   syn;
  logic [CNT_W-1:0] cmask;
  logic [CNT_W-1:0] rld;
  logic             run;
  logic             enc;
  logic             psc_hit;
  logic             enc_step;
  logic             enc_up;
  logic             tick;
  logic             down;
  logic             upd;
  logic             hall_x;
  logic [NCH:0]     stat_set;
  logic [NCH:0]     stat_clr;
  logic [NCH-1:0]   cap_ev;
  cnt_mode_t        mode;

  // Compare register decode: hit flag and channel index
  function automatic logic [2:0] cmp_sel(input logic [7:0] a);
    cmp_sel = {(a[7:4] == A_CMP_HI) && (a[1:0] == 2'h0), a[3:2]};
  endfunction : cmp_sel

  // ****************************************
  // Pin synchroniser
  // ****************************************
  sync2_bus #(
    .W (NCH)
  ) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (ch_in),
    .q       (syn)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    logic [1:0] md;
    logic       cin;
    logic       cprev;
    logic       edg;
    logic [2:0] sel;
    md = 2'h0;
    cin = 1'b0;
    cprev = 1'b0;
    edg = 1'b0;
    sel = cmp_sel(addr);
    s_nxt = s_r;
    s_nxt.dma = 1'b0;
    s_nxt.trig_o = 1'b0;
    s_nxt.rdata = '0;
    stat_set = '0;
    stat_clr = '0;
    cap_ev = '0;
    upd = 1'b0;
    cmask = s_r.ctrl[C_W16] ? MASK16 : MASK32;
    rld = s_r.reload & cmask;
    enc = s_r.ctrl[C_ENC];
    run = s_r.ctrl[C_EN] && !(dbg_halt && s_r.ctrl[C_FRZ]);
    psc_hit = (s_r.psc_cnt >= s_r.presc);
    enc_step = (syn[0] ^ s_r.in_d[0]) | (syn[1] ^ s_r.in_d[1]);
    enc_up = syn[0] ^ s_r.in_d[1];
    tick = run && (enc ? enc_step : psc_hit);
    mode = cnt_mode_t'(s_r.ctrl[C_MD +: 2]);
    down = enc ? !enc_up
               : (mode == CNT_DOWN) || (mode == CNT_CENTER && s_r.dir_dn);
    hall_x = ^syn[2:0];
    s_nxt.in_d = syn;
    s_nxt.hall_d = hall_x;

    if (run && !enc)
      s_nxt.psc_cnt = psc_hit ? '0 : s_r.psc_cnt + 16'h0001;

    if (tick)
    begin
      if (down)
      begin
        if (s_r.cnt == '0)
        begin
          upd = 1'b1;
          if (mode == CNT_CENTER && !enc)
          begin
            s_nxt.dir_dn = 1'b0;
            s_nxt.cnt = {31'h0, rld != '0};
          end
          else
            s_nxt.cnt = rld;
        end
        else
          s_nxt.cnt = s_r.cnt - 32'h1;
      end
      else
      begin
        if (s_r.cnt >= rld)
        begin
          upd = 1'b1;
          if (mode == CNT_CENTER && !enc)
          begin
            s_nxt.dir_dn = 1'b1;
            s_nxt.cnt = (rld == '0) ? '0 : rld - 32'h1;
          end
          else
            s_nxt.cnt = '0;
        end
        else
          s_nxt.cnt = s_r.cnt + 32'h1;
      end
    end

    if (upd)
    begin
      stat_set[0] = 1'b1;
      s_nxt.trig_o = 1'b1;
      s_nxt.dma = s_r.ctrl[C_DMA];
      if (s_r.ctrl[C_OPM])
        s_nxt.ctrl[C_EN] = 1'b0;
    end

    if (trig_in && s_r.ctrl[C_SLV])
      s_nxt.ctrl[C_EN] = 1'b1;

    for (int i = 0; i < NCH; i++)
    begin
      md = s_r.chmode[i*CH_FW +: 2];
      if (i == 0 && s_r.ctrl[C_HALL])
      begin
        cin = hall_x;
        cprev = s_r.hall_d;
        edg = cin != cprev;
      end
      else
      begin
        cin = syn[i];
        cprev = s_r.in_d[i];
        edg = s_r.chmode[i*CH_FW+CH_FALL] ? (cprev && !cin) : (!cprev && cin);
      end
      if (md == CH_CAPTURE && edg)
      begin
        cap_ev[i] = 1'b1;
        s_nxt.cmp[i] = s_r.cnt;
        stat_set[i+1] = 1'b1;
      end
      if ((md == CH_TOGGLE || md == CH_PWM) && tick && s_r.cnt == s_r.cmp[i])
      begin
        stat_set[i+1] = 1'b1;
        if (md == CH_TOGGLE)
          s_nxt.tgl[i] = !s_r.tgl[i];
      end
      // edge or centre from count mode
      // without CH_INV, zero gives low, above reload gives high
      if (md == CH_PWM)
        s_nxt.oc[i] = (s_r.cnt < s_r.cmp[i]) ^ s_r.chmode[i*CH_FW+CH_INV];
      else if (md == CH_TOGGLE)
        s_nxt.oc[i] = s_r.tgl[i];
      else
        s_nxt.oc[i] = 1'b0;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (wr_stb)
    begin
      unique case (addr)
        A_CTRL:   s_nxt.ctrl = wdata[CTL_W-1:0];
        A_PRESC:  s_nxt.presc = wdata[PSC_W-1:0];
        A_RELOAD: s_nxt.reload = wdata;
        A_COUNT:  s_nxt.cnt = wdata;
        A_CHMODE: s_nxt.chmode = wdata[NCH*CH_FW-1:0];
        A_DEAD:   s_nxt.dead = wdata[DT_W-1:0];
        A_MASK:   s_nxt.mask = wdata[NCH:0];
        default:
        begin
          if (sel[2])
            s_nxt.cmp[sel[1:0]] = wdata;
        end
      endcase
    end
    s_nxt.cnt = s_nxt.cnt & cmask;

    // ****************************************
    // Register reads
    // ****************************************
    if (rd_stb)
    begin
      unique case (addr)
        A_CTRL:   s_nxt.rdata = 32'(s_r.ctrl);
        A_PRESC:  s_nxt.rdata = 32'(s_r.presc);
        A_RELOAD: s_nxt.rdata = s_r.reload;
        A_COUNT:  s_nxt.rdata = s_r.cnt;
        A_CHMODE: s_nxt.rdata = 32'(s_r.chmode);
        A_DEAD:   s_nxt.rdata = 32'(s_r.dead);
        A_MASK:   s_nxt.rdata = 32'(s_r.mask);
        A_STAT:
        begin
          s_nxt.rdata = 32'(s_r.stat);
          stat_clr = '1;
        end
        default:
        begin
          if (sel[2])
            s_nxt.rdata = s_r.cmp[sel[1:0]];
        end
      endcase
    end
    // New events win over the read-clear
    s_nxt.stat = (s_r.stat & ~stat_clr) | stat_set;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.presc <= PRESC_RST;
      s_r.reload <= RELOAD_RST;
      s_r.dead <= DEAD_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // dead-time pairs
  for (genvar g = 0; g < NPAIR; g++)
  begin : g_pair
    dead_time_pair u_dt (
      .sys_clk (sys_clk),
      .srst    (srst),
      .ref_in  (s_r.oc[g]),
      .dead    (s_r.dead),
      .out_p   (ch_out[g]),
      .out_n   (ch_out_n[g])
    );
  end

  assign ch_out[NCH-1] = s_r.oc[NCH-1];
  assign rdata = s_r.rdata;
  assign trig_out = s_r.trig_o;
  assign dma_req = s_r.dma;
  assign irq = |(s_r.stat & s_r.mask);

  // ****************************************
  // Checks
  // ****************************************
  AST_W16: assert property (@(posedge sys_clk) disable iff (srst)
    $past(s_r.ctrl[C_W16]) |-> (s_r.cnt[31:16] == 16'h0000))
    else $error("Narrow counter has high bits set");

  AST_UP_WRAP: assert property (@(posedge sys_clk) disable iff (srst)
    (tick && !down && mode == CNT_UP && s_r.cnt >= rld && !wr_stb) |=> (s_r.cnt == '0))
    else $error("Upcounter did not wrap to zero");

  AST_DN_RELOAD: assert property (@(posedge sys_clk) disable iff (srst)
    (tick && down && !enc && mode == CNT_DOWN && s_r.cnt == '0 && !wr_stb)
      |=> (s_r.cnt == $past(rld)))
    else $error("Downcounter did not reload");

  AST_PSC: assert property (@(posedge sys_clk) disable iff (srst)
    (run && !enc && !psc_hit && !wr_stb) |=> (s_r.psc_cnt == $past(s_r.psc_cnt) + 16'h0001))
    else $error("Prescaler did not advance");

  AST_CAP: assert property (@(posedge sys_clk) disable iff (srst)
    (cap_ev[0] && !wr_stb) |=> (s_r.cmp[0] == $past(s_r.cnt) && s_r.stat[1]))
    else $error("Capture value or flag missing");

  AST_PWM_LOW: assert property (@(posedge sys_clk) disable iff (srst)
    (s_r.chmode[1:0] == CH_PWM && !s_r.chmode[CH_INV] && s_r.cmp[0] == '0) |=> !s_r.oc[0])
    else $error("Zero duty not held low");

  AST_UPD: assert property (@(posedge sys_clk) disable iff (srst)
    upd |=> (s_r.stat[0] && trig_out))
    else $error("Update flag or trigger missing");

  AST_DMA: assert property (@(posedge sys_clk) disable iff (srst)
    dma_req == $past(upd && s_r.ctrl[C_DMA]))
    else $error("DMA request does not follow the update event");

  AST_FRZ: assert property (@(posedge sys_clk) disable iff (srst)
    (dbg_halt && s_r.ctrl[C_FRZ] && !wr_stb) |=> $stable(s_r.cnt))
    else $error("Counter moved while frozen");

  AST_SLV: assert property (@(posedge sys_clk) disable iff (srst)
    (trig_in && s_r.ctrl[C_SLV] && !wr_stb) |=> s_r.ctrl[C_EN])
    else $error("Link trigger did not start timer");

endmodule : capture_pwm_timer
`default_nettype wire

// *** tb/far_side_model.sv ***
// Encoder, capture pin and sibling trigger model for the timer's far side
`timescale 1ns/1ns
`default_nettype none
module far_side_model
  import timer_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           step,
  input  wire logic           fire,
  input  wire logic [1:0]     lvl,
  output logic      [NCH-1:0] ch_in,
  output logic                trig_in
);
  logic [1:0] ph_r   = 2'h0;
  logic       trig_r = 1'b0;

  // ****************
  // Pin drive
  // ****************
  // quadrature gray steps
  always_ff @(posedge sys_clk)
  begin
    if (step)
    begin
      ph_r <= ph_r + 2'h1;
    end
    trig_r <= fire;
  end

  // Gray code keeps one line changing per step
  assign ch_in   = {lvl, ph_r[1], ph_r[1] ^ ph_r[0]};
  assign trig_in = trig_r;
endmodule : far_side_model
`default_nettype wire

// *** tb/capture_pwm_timer_test.sv ***
// Self-checking bench for the capture/PWM timer
`timescale 1ns/1ns
`default_nettype none
module capture_pwm_timer_test
  import timer_pkg::*;
;
  // ****************
  // Signals
  // ****************
  localparam logic [CNT_W-1:0] CV [4] = '{32'h201, 32'h3, 32'h7, 32'h9};
  localparam logic [CNT_W-1:0] PV [4] = '{32'h2, 32'h2, 32'h2, 32'h0};
  localparam logic [CNT_W-1:0] RV [4] = '{32'h3, 32'h3, 32'h3, 32'h10003};
  localparam logic [CNT_W-1:0] EV [4] = '{32'hC, 32'hC, 32'h9, 32'h4};
  localparam logic [CNT_W-1:0] MV [3] = '{32'h0, 32'h3, 32'hA};
  localparam logic [CNT_W-1:0] HV [6] = '{32'h0, 32'h3, 32'hA, 32'hA, 32'h7, 32'h0};
  logic             sys_clk  = 1'b0;
  logic             srst     = 1'b1;
  logic [7:0]       addr     = 8'h00;
  logic [CNT_W-1:0] wdata    = 32'h0;
  logic             wr_stb   = 1'b0;
  logic             rd_stb   = 1'b0;
  logic             dbg_halt = 1'b0;
  logic             step     = 1'b0;
  logic             fire     = 1'b0;
  logic [1:0]       lvl      = 2'h0;
  logic [CNT_W-1:0] rdata;
  logic [CNT_W-1:0] rd_v;
  logic [NCH-1:0]   ch_in;
  logic [NCH-1:0]   ch_out;
  logic [NPAIR-1:0] ch_out_n;
  logic             trig_in;
  logic             trig_out;
  logic             dma_req;
  logic             irq;
  int               n_fail          = 0;
  int               samples_checked = 0;
  int               n;
  int               hi;

  capture_pwm_timer dut (.sys_clk(sys_clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ch_in(ch_in), .trig_in(trig_in),
    .dbg_halt(dbg_halt), .ch_out(ch_out), .ch_out_n(ch_out_n), .trig_out(trig_out),
    .dma_req(dma_req), .irq(irq));

  far_side_model far (.sys_clk(sys_clk), .step(step), .fire(fire), .lvl(lvl),
    .ch_in(ch_in), .trig_in(trig_in));

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  // ****************
  // Tasks
  // ****************
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic check_val(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask : check_bit

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [CNT_W-1:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [CNT_W-1:0] d);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [CNT_W-1:0] e);
    logic [CNT_W-1:0] d;
    rd(a, d);
    check_val(d, e);
  endtask : rd_chk

  // Cycles until the next update pulse, capped at lim
  task automatic wait_trig(input int lim, output int k);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end while (k < lim && trig_out !== 1'b1);
  endtask : wait_trig

  // ****************
  // Tests
  // ****************
  initial
  begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    wr(A_STAT, 32'hFFFFFFFF);
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_RELOAD, RELOAD_RST); // wide reload
    rd_chk(A_DEAD, 32'h0);
    rd_chk(A_STAT, 32'h0); // no event yet
    rd_chk(8'h3C, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(A_CTRL, 32'h0);
      wr(A_COUNT, 32'h0);
      wr(A_PRESC, PV[i]);
      wr(A_RELOAD, RV[i]);
      wr(A_CTRL, CV[i]);
      wait_trig(100, n);
      wait_trig(100, n);
      check_bit(dma_req, CV[i][C_DMA]); // dma beside update
      check_val(32'(n), EV[i]); // period
    end
    wr(A_CTRL, 32'h0);
    dbg_halt <= 1'b1;
    wr(A_RELOAD, 32'h3);
    wr(A_PRESC, 32'h0);
    wr(A_CTRL, 32'h21);
    wait_trig(40, n);
    check_val(32'(n), 32'h28); // frozen
    dbg_halt <= 1'b0;
    wait_trig(40, n);
    wait_trig(40, n);
    check_val(32'(n), 32'h4); // resumes
    wr(A_CTRL, 32'h0);
    cyc(2);
    check_bit(irq, 1'b0); // masked
    wr(A_MASK, 32'h1);
    cyc(1);
    check_bit(irq, 1'b1); // unmasked
    rd(A_STAT, rd_v);
    check_bit(rd_v[0], 1'b1); // sticky flag
    cyc(1);
    check_bit(irq, 1'b0); // read clears
    for (int e = 0; e < 2; e++)
    begin
      wr(A_CHMODE, (e != 0) ? 32'h500 : 32'h100);
      wr(A_COUNT, (e != 0) ? 32'h66 : 32'h55);
      lvl[0] <= (e == 0);
      cyc(8);
      rd_chk(8'h28, (e != 0) ? 32'h66 : 32'h55); // latched count
      rd_chk(A_STAT, 32'h8); // capture flag
    end
    wr(A_RELOAD, 32'h9);
    wr(A_COUNT, 32'h0);
    wr(A_CTRL, 32'h1);
    for (int c = 0; c < 6; c++)
    begin
      wr(A_CHMODE, (c > 2) ? 32'hA000 : 32'h2000);
      wr(8'h2C, MV[c % 3]);
      cyc(12);
      hi = 0;
      repeat (10)
      begin
        cyc(1);
        hi += (ch_out[3] === 1'b1);
      end
      check_val(32'(hi), HV[c]); // duty
    end
    wr(A_CHMODE, 32'h2000);
    wr(8'h2C, 32'h3);
    wr(A_CTRL, 32'h7);
    cyc(20);
    hi = 0;
    repeat (18)
    begin
      cyc(1);
      hi += (ch_out[3] === 1'b1);
    end
    check_val(32'(hi), 32'h5); // centre-aligned duty
    wr(A_CHMODE, 32'h222);
    for (int d = 0; d < 2; d++)
    begin
      wr(A_DEAD, (d != 0) ? 32'h5 : 32'h0);
      wr(8'h28, 32'hA);
      wr(8'h24, 32'hA);
      wr(8'h20, 32'hA);
      cyc(20);
      check_val(32'({ch_out[2:0], ch_out_n}), 32'h38); // three pairs
      wr(8'h28, 32'h0);
      wr(8'h24, 32'h0);
      wr(8'h20, 32'h0);
      n = 0;
      while (ch_out[0] !== 1'b0 && n < 20)
      begin
        cyc(1);
        n++;
      end
      n = 0;
      while (ch_out_n[0] !== 1'b1 && n < 20)
      begin
        cyc(1);
        n++;
      end
      check_val(32'(n), (d != 0) ? 32'h6 : 32'h1); // gap
    end
    wr(A_CTRL, 32'h40);
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    cyc(3);
    rd_chk(A_CTRL, 32'h41); // link start
    wr(A_CTRL, 32'h0);
    wr(A_RELOAD, 32'hF);
    wr(A_COUNT, 32'h0);
    wr(A_CTRL, 32'h81);
    repeat (4)
    begin
      step <= 1'b1;
      cyc(1);
      step <= 1'b0;
      cyc(3);
    end
    cyc(4);
    rd(A_COUNT, rd_v);
    check_val(rd_v, 32'h4); // four edges
    wr(A_CTRL, 32'h100);
    wr(A_CHMODE, 32'h1);
    wr(A_COUNT, 32'h77);
    lvl[0] <= 1'b1;
    cyc(6);
    rd_chk(8'h20, 32'h77); // hall capture
    wr(A_CTRL, 32'h0);
    wr(A_CHMODE, 32'h30);
    wr(A_COUNT, 32'h0);
    wr(A_RELOAD, 32'h3);
    wr(8'h24, 32'h2);
    rd(A_STAT, rd_v);
    wr(A_CTRL, 32'h11);
    cyc(12);
    rd_chk(A_CTRL, 32'h10); // one-pulse stop
    rd_chk(A_COUNT, 32'h0); // stopped at wrap
    rd_chk(A_STAT, 32'h5); // match and update flags
    check_val(32'({ch_out[1], ch_out_n[1]}), 32'h2); // toggled pair
    wrap_up();
  end
endmodule : capture_pwm_timer_test
`default_nettype wire
